// ### logic/asdp_pkg.sv
// Constants, register map and types of the asynchronous serial display port
// How it works
// - Port speaks 3-wire, 4-wire and two 5-wire serial forms, chosen per display.
// - 5-wire form 1: select sampled on serial clock; form 2: on chip select.
// - 3-wire keeps separate internal in/out lines plus an output enable for the mux.
// - Optional preamble with programmable length and bit values, length zero omits it.
// - Read/write and register-select bits follow the preamble in a programmable order.
// - Read/write bit can be disabled, leaving only the register-select bit.
// - Data phase carries one word or a burst of words within one transfer.
// - Two independent display configurations, one per attached display.
// - Read period is fast clock period times ceil(read period / clock setting).
// - Write period is fast clock period times ceil(write period / clock setting).
// - Read down time is half clock times ceil(2*read down / clock setting).
// - Read up time is half clock times ceil(2*read up / clock setting).
// - Write down and up times use the same half-cycle formula with write settings.
// - Read clock is low from up time to down time, high otherwise.
// - Write clock is low for down minus up time, high for the rest.
// - Read controls set up by read up time, held period minus down time.
// - Write controls set up by write up time, held period minus down time.
// - Write data leads the clock edge by down time, stable period minus down time.
// - Periods, edges, clock setting and sampling point sit in software registers.
package asdp_pkg;

    localparam int unsigned CLK_PERIOD_PS = 4000;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_TXDATA  = 8'h04;
    localparam logic [7:0] ADDR_STATUS  = 8'h08;
    localparam logic [7:0] ADDR_RXDATA  = 8'h0C;
    localparam logic [7:0] ADDR_CONF0   = 8'h10;
    localparam logic [7:0] ADDR_CONF1   = 8'h14;
    localparam logic [7:0] ADDR_PRE0    = 8'h18;
    localparam logic [7:0] ADDR_PRE1    = 8'h1C;
    localparam logic [7:0] ADDR_TIME1_0 = 8'h20;
    localparam logic [7:0] ADDR_TIME1_1 = 8'h24;
    localparam logic [7:0] ADDR_TIME2_0 = 8'h28;
    localparam logic [7:0] ADDR_TIME2_1 = 8'h2C;
    localparam logic [7:0] ADDR_HSP     = 8'h30;

    // Control register fields
    localparam int CT_GO        = 0;
    localparam int CT_RW        = 1;
    localparam int CT_RS        = 2;
    localparam int CT_DISP      = 3;
    localparam int CT_BURST_LSB = 8;
    localparam int CT_BURST_W   = 8;

    // Status register fields
    localparam int ST_BUSY    = 0;
    localparam int ST_TXFULL  = 1;
    localparam int ST_RXVALID = 2;
    localparam int ST_STALL   = 3;

    // serial_display_config fields
    localparam int CF_MODE_LSB = 0;
    localparam int CF_MODE_W   = 2;
    localparam int CF_RWFIRST  = 2;
    localparam int CF_RWEN     = 3;
    localparam int CF_CSPOL    = 4;
    localparam int CF_CLKPOL   = 5;
    localparam int CF_WLEN_LSB = 6;
    localparam int CF_WLEN_W   = 4;
    localparam int CF_PLEN_LSB = 10;
    localparam int CF_PLEN_W   = 5;

    // Timing fields, all eight bits wide
    localparam int TF_W        = 8;
    localparam int T1_PERWR    = 0;
    localparam int T1_PERRD    = 8;
    localparam int T1_RDPOINT  = 16;
    localparam int T2_DNWR     = 0;
    localparam int T2_UPWR     = 8;
    localparam int T2_DNRD     = 16;
    localparam int T2_UPRD     = 24;

    // Interface forms
    localparam logic [1:0] MODE_3W  = 2'h0;
    localparam logic [1:0] MODE_4W  = 2'h1;
    localparam logic [1:0] MODE_5W1 = 2'h2;
    localparam logic [1:0] MODE_5W2 = 2'h3;

    // Reset values
    localparam logic [15:0] CONF_RST  = 16'h01C8;
    localparam logic [15:0] PRE_RST   = 16'h0000;
    localparam logic [23:0] TIME1_RST = 24'h060808;
    localparam logic [31:0] TIME2_RST = 32'h02060206;
    localparam logic [7:0]  HSP_RST   = 8'h01;

    typedef enum logic [2:0] {
        ASDP_IDLE, ASDP_LOAD, ASDP_RSSET, ASDP_PRE, ASDP_HDR, ASDP_DATA, ASDP_STALL
    } asdp_phase_t;

    typedef struct packed {
        asdp_phase_t      phase;
        logic [1:0][15:0] conf;
        logic [1:0][15:0] pre;
        logic [1:0][23:0] tim1;
        logic [1:0][31:0] tim2;
        logic [7:0]       hsp;
        logic             rw;
        logic             rs;
        logic             disp;
        logic [7:0]       burst_left;
        logic [15:0]      tx_data;
        logic             tx_full;
        logic [15:0]      rx_data;
        logic             rx_valid;
        logic [15:0]      shift;
        logic [4:0]       bitn;
        logic [8:0]       t;
        logic [8:0]       per;
        logic [8:0]       up2;
        logic [8:0]       dn2;
        logic [8:0]       drp;
        logic [31:0]      rdata;
        logic [1:0]       cs;
        logic             sclk;
        logic             sdo;
        logic             oe;
        logic             rsp;
    } asdp_state_t;

    // Ceiling of a / d in fast clock units; a zero divisor counts as one
    function automatic logic [8:0] asdp_ceil(input logic [8:0] a, input logic [7:0] d);
        logic [9:0] dv;
        logic [9:0] q;
        dv = (d == 8'h00) ? 10'h001 : {2'h0, d};
        q  = ({1'b0, a} + dv - 10'h001) / dv;
        return q[8:0];
    endfunction

endpackage

// ### logic/asdp_port.sv
// Asynchronous serial display port master with its register file
`timescale 1ns/10ps
`default_nettype none
module asdp_port
    import asdp_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        resetn_in,
    // Register port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    // Display pins
    output logic      [1:0]  display_chip_select_out,
    output logic             serial_display_clock_out,
    output logic             serial_data_out_internal_out,
    output logic             serial_data_out_enable_out,
    output logic             register_select_bit_out,
    input  wire logic        serial_data_in_internal_in
);

    logic        rst_meta;
    logic        rst_n;
    asdp_state_t s;
    asdp_state_t n;

    logic [15:0] cfg;
    logic [1:0]  mode;
    logic        five;
    logic [1:0]  hbits;
    logic [1:0]  hcnt;
    logic [4:0]  plen;
    logic [4:0]  wbits;
    logic        bit_end;
    logic [8:0]  samp;
    logic        low_win;
    logic        toggling;
    logic        cs_act;
    logic        load_word;
    logic [15:0] rx_next;
    logic [23:0] t1;
    logic [31:0] t2;
    asdp_phase_t data_ph;
    asdp_phase_t hdr_on;
    asdp_phase_t pre_on;

    // Reset released through two flops
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    always_comb begin
        n        = s;
        cfg      = s.conf[s.disp];
        mode     = cfg[CF_MODE_LSB +: CF_MODE_W];
        five     = (mode == MODE_5W1) || (mode == MODE_5W2);
        plen     = cfg[CF_PLEN_LSB +: CF_PLEN_W];
        wbits    = {1'b0, cfg[CF_WLEN_LSB +: CF_WLEN_W]} + 5'h01;
        t1       = s.tim1[s.disp];
        t2       = s.tim2[s.disp];
        bit_end  = (s.t == s.per - 9'h001);
        samp     = (s.drp >= s.per) ? s.per - 9'h001 : s.drp;
        load_word = 1'b0;
        rx_next  = {s.shift[14:0], serial_data_in_internal_in};
        // Header layout; in 5-wire forms the select travels on its own pin
        if (five) begin
            hcnt  = cfg[CF_RWEN] ? 2'h1 : 2'h0;
            hbits = {s.rw, 1'b0};
        end else if (cfg[CF_RWEN]) begin
            hcnt  = 2'h2;
            hbits = cfg[CF_RWFIRST] ? {s.rw, s.rs} : {s.rs, s.rw};
        end else begin
            hcnt  = 2'h1;
            hbits = {s.rs, 1'b0};
        end
        // A write word may only start once software has supplied it
        data_ph = (!s.rw && !s.tx_full) ? ASDP_STALL : ASDP_DATA;
        hdr_on  = (hcnt != 2'h0) ? ASDP_HDR : data_ph;
        pre_on  = (plen != 5'h00) ? ASDP_PRE : hdr_on;

        // Reading the receive register clears the flag; a new word wins below
        if (reg_rd_in && reg_addr_in == ADDR_RXDATA) begin
            n.rx_valid = 1'b0;
        end

        unique case (s.phase)
            ASDP_IDLE: begin
                n.t    = 9'h000;
                n.bitn = 5'h00;
            end
            ASDP_LOAD: begin
                if (s.rw) begin
                    n.per = asdp_ceil({1'b0, t1[T1_PERRD +: TF_W]}, s.hsp);
                    n.dn2 = asdp_ceil({t2[T2_DNRD +: TF_W], 1'b0}, s.hsp);
                    n.up2 = asdp_ceil({t2[T2_UPRD +: TF_W], 1'b0}, s.hsp);
                end else begin
                    n.per = asdp_ceil({1'b0, t1[T1_PERWR +: TF_W]}, s.hsp);
                    n.dn2 = asdp_ceil({t2[T2_DNWR +: TF_W], 1'b0}, s.hsp);
                    n.up2 = asdp_ceil({t2[T2_UPWR +: TF_W], 1'b0}, s.hsp);
                end
                n.drp = asdp_ceil({1'b0, t1[T1_RDPOINT +: TF_W]}, s.hsp);
                if (n.per == 9'h000) begin
                    n.per = 9'h001;
                end
                n.t    = 9'h000;
                n.bitn = 5'h00;
                // Form 2 needs the select settled before chip select moves
                n.phase = (mode == MODE_5W2) ? ASDP_RSSET : pre_on;
                load_word = (n.phase == ASDP_DATA);
            end
            ASDP_STALL: begin
                n.t    = 9'h000;
                n.bitn = 5'h00;
                if (s.tx_full) begin
                    n.phase   = ASDP_DATA;
                    load_word = 1'b1;
                end
            end
            default: begin
                n.t = bit_end ? 9'h000 : s.t + 9'h001;
                if (s.phase == ASDP_DATA && s.rw && s.t == samp) begin
                    n.shift = rx_next;
                end
                if (bit_end) begin
                    n.bitn = s.bitn + 5'h01;
                    if (s.phase == ASDP_DATA && !s.rw) begin
                        n.shift = {s.shift[14:0], 1'b0};
                    end
                    unique case (s.phase)
                        ASDP_RSSET: begin
                            n.bitn  = 5'h00;
                            n.phase = pre_on;
                        end
                        ASDP_PRE: begin
                            if (s.bitn == plen - 5'h01) begin
                                n.bitn  = 5'h00;
                                n.phase = hdr_on;
                            end
                        end
                        ASDP_HDR: begin
                            if (s.bitn == {3'h0, hcnt} - 5'h01) begin
                                n.bitn  = 5'h00;
                                n.phase = data_ph;
                            end
                        end
                        default: begin
                            if (s.bitn == wbits - 5'h01) begin
                                n.bitn = 5'h00;
                                if (s.rw) begin
                                    n.rx_data  = n.shift;
                                    n.rx_valid = 1'b1;
                                end
                                if (s.burst_left != 8'h00) begin
                                    n.burst_left = s.burst_left - 8'h01;
                                    n.phase      = data_ph;
                                end else begin
                                    n.phase = ASDP_IDLE;
                                end
                            end
                        end
                    endcase
                    load_word = (n.phase == ASDP_DATA) && (n.bitn == 5'h00);
                end
            end
        endcase

        // Write words are left-aligned so the first bit sits at the top
        if (load_word) begin
            if (s.rw) begin
                n.shift = 16'h0000;
            end else begin
                n.shift   = s.tx_data << (5'h10 - wbits);
                n.tx_full = 1'b0;
            end
        end

        // Register writes after the engine so a refill in the take cycle is kept
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                ADDR_CTRL: begin
                    if (s.phase == ASDP_IDLE && reg_wdata_in[CT_GO]) begin
                        n.rw         = reg_wdata_in[CT_RW];
                        n.rs         = reg_wdata_in[CT_RS];
                        n.disp       = reg_wdata_in[CT_DISP];
                        n.burst_left = reg_wdata_in[CT_BURST_LSB +: CT_BURST_W];
                        n.phase      = ASDP_LOAD;
                    end
                end
                ADDR_TXDATA: begin
                    n.tx_data = reg_wdata_in[15:0];
                    n.tx_full = 1'b1;
                end
                ADDR_CONF0:   n.conf[0] = reg_wdata_in[15:0];
                ADDR_CONF1:   n.conf[1] = reg_wdata_in[15:0];
                ADDR_PRE0:    n.pre[0]  = reg_wdata_in[15:0];
                ADDR_PRE1:    n.pre[1]  = reg_wdata_in[15:0];
                ADDR_TIME1_0: n.tim1[0] = reg_wdata_in[23:0];
                ADDR_TIME1_1: n.tim1[1] = reg_wdata_in[23:0];
                ADDR_TIME2_0: n.tim2[0] = reg_wdata_in;
                ADDR_TIME2_1: n.tim2[1] = reg_wdata_in;
                ADDR_HSP:     n.hsp     = reg_wdata_in[7:0];
                default: ;
            endcase
        end

        // Read data stands for one cycle only, zero otherwise
        n.rdata = 32'h0000_0000;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                ADDR_STATUS: begin
                    n.rdata[ST_BUSY]    = (s.phase != ASDP_IDLE);
                    n.rdata[ST_TXFULL]  = s.tx_full;
                    n.rdata[ST_RXVALID] = s.rx_valid;
                    n.rdata[ST_STALL]   = (s.phase == ASDP_STALL);
                end
                ADDR_TXDATA:  n.rdata = {16'h0000, s.tx_data};
                ADDR_RXDATA:  n.rdata = {16'h0000, s.rx_data};
                ADDR_CONF0:   n.rdata = {16'h0000, s.conf[0]};
                ADDR_CONF1:   n.rdata = {16'h0000, s.conf[1]};
                ADDR_PRE0:    n.rdata = {16'h0000, s.pre[0]};
                ADDR_PRE1:    n.rdata = {16'h0000, s.pre[1]};
                ADDR_TIME1_0: n.rdata = {8'h00, s.tim1[0]};
                ADDR_TIME1_1: n.rdata = {8'h00, s.tim1[1]};
                ADDR_TIME2_0: n.rdata = s.tim2[0];
                ADDR_TIME2_1: n.rdata = s.tim2[1];
                ADDR_HSP:     n.rdata = {24'h000000, s.hsp};
                default:      n.rdata = 32'h0000_0000;
            endcase
        end

        // Pins follow the engine one cycle later, keeping all edges aligned
        toggling = (s.phase == ASDP_PRE) || (s.phase == ASDP_HDR) || (s.phase == ASDP_DATA);
        cs_act   = toggling || (s.phase == ASDP_STALL);
        // Edges land on whole cycles; half-cycle settings round up
        low_win  = ({s.t, 1'b0} >= {1'b0, s.up2}) && ({s.t, 1'b0} < {1'b0, s.dn2});
        n.sclk   = (toggling ? ~low_win : 1'b1) ^ cfg[CF_CLKPOL];
        for (int i = 0; i < 2; i++) begin
            n.cs[i] = (cs_act && s.disp == i[0]) ? s.conf[i][CF_CSPOL]
                                                : ~s.conf[i][CF_CSPOL];
        end
        // Bits change at bit start: setup is up time for controls, down for data
        unique case (s.phase)
            ASDP_PRE:  n.sdo = s.pre[s.disp][4'(plen - 5'h01 - s.bitn)];
            ASDP_HDR:  n.sdo = hbits[~s.bitn[0]];
            ASDP_DATA: n.sdo = s.rw ? 1'b0 : s.shift[15];
            default:   n.sdo = 1'b0;
        endcase
        n.oe  = !(s.phase == ASDP_DATA && s.rw);
        n.rsp = five ? s.rs : 1'b0;
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            s            <= '0;
            s.phase      <= ASDP_IDLE;
            s.conf       <= {CONF_RST, CONF_RST};
            s.pre        <= {PRE_RST, PRE_RST};
            s.tim1       <= {TIME1_RST, TIME1_RST};
            s.tim2       <= {TIME2_RST, TIME2_RST};
            s.hsp        <= HSP_RST;
            s.per        <= 9'h001;
            s.cs         <= 2'h3;
            s.sclk       <= 1'b1;
            s.oe         <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign reg_rdata_out                = s.rdata;
    assign display_chip_select_out      = s.cs;
    assign serial_display_clock_out     = s.sclk;
    assign serial_data_out_internal_out = s.sdo;
    assign serial_data_out_enable_out   = s.oe;
    assign register_select_bit_out      = s.rsp;

endmodule // asdp_port
`default_nettype wire

// ### testbench/asdp_display_model.sv
// Behavioural display on the serial port, capturing writes and answering reads
`timescale 1ns/10ps
`default_nettype none
module asdp_display_model (
    // Display pins
    input  wire logic [1:0]  cs_in,
    input  wire logic        sclk_in,
    input  wire logic        sdo_in,
    input  wire logic        oe_in,
    input  wire logic        rs_in,
    // Reply pattern and capture
    input  wire logic [15:0] reply_in,
    output logic             sdi_out,
    output logic [31:0]      cap_out,
    output logic [5:0]       nbits_out,
    output logic             rs_cap_out
);
    logic        frame_n;
    logic [15:0] rsh = 16'h0000;
    logic        last = 1'b0;
    logic        drv = 1'b0;
    initial begin
        cap_out = 32'h0;
        nbits_out = 6'h0;
        rs_cap_out = 1'b0;
    end
    assign frame_n = &cs_in;
    // Released line shows the inverse of its last level until the first reply bit of the frame, then shows the latest reply bit
    assign sdi_out = oe_in ? sdo_in : (drv ? last : ~last);
    always @(negedge frame_n) begin
        cap_out = 32'h0;
        nbits_out = 6'h0;
        rsh = reply_in;
        drv = 1'b0;
        rs_cap_out = rs_in;
    end
    always @(posedge sclk_in) begin
        if (!frame_n && oe_in) begin
            cap_out = {cap_out[30:0], sdo_in};
            nbits_out = nbits_out + 6'h1;
            rs_cap_out = rs_in;
        end
    end
    // New bit on the falling edge holds across the next sampling point
    always @(negedge sclk_in) begin
        if (!frame_n && !oe_in) begin
            last = rsh[15];
            rsh = {rsh[14:0], 1'b0};
            drv = 1'b1;
        end
    end
endmodule // asdp_display_model
`default_nettype wire

// ### testbench/asdp_port_props.sv
// Checker of pin and register port behaviour of the serial display port
`timescale 1ns/10ps
`default_nettype none
module asdp_port_props
    import asdp_pkg::*;
(
    // Clock and reset
    input wire logic        mclk_in,
    input wire logic        resetn_in,
    // Register port
    input wire logic [7:0]  reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    // Display pins
    input wire logic [1:0]  display_chip_select_out,
    input wire logic        serial_display_clock_out,
    input wire logic        serial_data_out_internal_out,
    input wire logic        serial_data_out_enable_out,
    input wire logic        register_select_bit_out,
    input wire logic        serial_data_in_internal_in
);
    logic       idle;
    logic       cur_rw;
    logic [2:0] quiet;
    // Only the default active-low select is watched; polarity stays at reset value here
    assign idle = &display_chip_select_out;
    // Idle clock level may move just after a start
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cur_rw <= 1'b0;
            quiet  <= 3'h7;
        end else if (reg_wr_in && reg_addr_in == ADDR_CTRL) begin
            cur_rw <= reg_wdata_in[CT_RW];
            quiet  <= 3'h7;
        end else if (quiet != 3'h0) begin
            quiet <= quiet - 3'h1;
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_frame_open;
        $rose(!idle);
    endsequence
    sequence s_busy_read;
        reg_rd_in && reg_addr_in == ADDR_STATUS && !idle ##1 !idle;
    endsequence
    property p_rdata_idle; !$past(reg_rd_in) |-> reg_rdata_out == 32'h0; endproperty
    property p_one_cs; display_chip_select_out != 2'h0; endproperty
    property p_oe_idle; idle && $past(idle) |-> serial_data_out_enable_out; endproperty
    property p_cs_hold; s_frame_open |-> !idle [*2]; endproperty
    property p_sclk_quiet;
        idle && $past(idle) && quiet == 3'h0 |-> $stable(serial_display_clock_out);
    endproperty
    property p_oe_write; !cur_rw |-> serial_data_out_enable_out; endproperty
    property p_oe_read; s_frame_open ##0 cur_rw |-> ##[1:1000] !serial_data_out_enable_out;
    endproperty
    property p_unmapped; reg_rd_in && reg_addr_in == 8'hFC |=> reg_rdata_out == 32'h0; endproperty
    property p_busy_frame; s_busy_read |-> reg_rdata_out[ST_BUSY]; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data off slot");
    a_one_cs: assert property (p_one_cs) else $error("both selects active");
    a_oe_idle: assert property (p_oe_idle) else $error("enable low when idle");
    a_cs_hold: assert property (p_cs_hold) else $error("select pulse too short");
    a_sclk_quiet: assert property (p_sclk_quiet) else $error("clock moved idle");
    a_oe_write: assert property (p_oe_write) else $error("enable low on write");
    a_oe_read: assert property (p_oe_read) else $error("enable never dropped");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_busy_frame: assert property (p_busy_frame) else $error("not busy in frame");
endmodule // asdp_port_props
bind asdp_port asdp_port_props u_props (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .display_chip_select_out(display_chip_select_out),
    .serial_display_clock_out(serial_display_clock_out),
    .serial_data_out_internal_out(serial_data_out_internal_out),
    .serial_data_out_enable_out(serial_data_out_enable_out),
    .register_select_bit_out(register_select_bit_out),
    .serial_data_in_internal_in(serial_data_in_internal_in));
`default_nettype wire

// ### testbench/asdp_port_tb.sv
// Self-checking bench for the serial display port
`timescale 1ns/10ps
`default_nettype none
module asdp_port_tb
    import asdp_pkg::*;
;
    typedef struct {logic [15:0] conf; logic [15:0] pre; logic [23:0] t1; logic [31:0] t2;
        logic [7:0] hsp; logic [31:0] ctl; logic [15:0] data; int nb; logic [31:0] cap;
        logic rs;} asdp_row_t;
    asdp_row_t rows [6] = '{
        '{16'h0DCC, 16'h5, 24'h060807, 32'h02060105, 8'h2, 32'h1, 16'hC3, 13, 32'h14C3, 1'b0},
        '{16'h00C0, 16'h0, 24'h060808, 32'h02060206, 8'h3, 32'h5, 16'h9, 5, 32'h19, 1'b0},
        '{16'h01C9, 16'h0, 24'h060808, 32'h02060206, 8'h1, 32'h1, 16'hFF, 10, 32'hFF, 1'b0},
        '{16'h01CA, 16'h0, 24'h060808, 32'h02060206, 8'h1, 32'h5, 16'h81, 9, 32'h81, 1'b1},
        '{16'h01CB, 16'h0, 24'h060808, 32'h02060206, 8'h1, 32'h5, 16'h81, 9, 32'h81, 1'b1},
        '{16'h01C8, 16'h0, 24'h060808, 32'h02060206, 8'h1, 32'h5, 16'h5A, 10, 32'h25A, 1'b0}};
    logic [7:0]  rst_a [8] = '{ADDR_CONF0, ADDR_CONF1, ADDR_PRE0, ADDR_TIME1_0, ADDR_TIME2_1,
        ADDR_HSP, 8'hFC, ADDR_STATUS};
    logic [31:0] rst_v [8] = '{32'h01C8, 32'h01C8, 32'h0, 32'h060808, 32'h02060206, 32'h1,
        32'h0, 32'h0};
    logic [7:0]  amap [6] = '{ADDR_CONF0, ADDR_PRE0, ADDR_TIME1_0, ADDR_TIME2_0, ADDR_HSP,
        ADDR_TXDATA};
    logic        mclk;
    logic        resetn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic [1:0]  cs;
    logic        sclk, sdo, oe, rsp, sdi, rs_cap;
    logic [15:0] reply = 16'h0000;
    logic [31:0] cap, frame_len = 32'h0, low_run = 32'h0, low_w = 32'h0, d;
    logic [5:0]  nbits;
    int          err_count = 0, total_checks = 0, cycles = 0;
    asdp_port dut (.mclk_in(mclk), .resetn_in(resetn), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .display_chip_select_out(cs),
        .serial_display_clock_out(sclk), .serial_data_out_internal_out(sdo),
        .serial_data_out_enable_out(oe), .register_select_bit_out(rsp),
        .serial_data_in_internal_in(sdi));
    asdp_display_model u_disp (.cs_in(cs), .sclk_in(sclk), .sdo_in(sdo), .oe_in(oe),
        .rs_in(rsp), .reply_in(reply), .sdi_out(sdi), .cap_out(cap), .nbits_out(nbits),
        .rs_cap_out(rs_cap));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (cs != 2'h3) frame_len <= frame_len + 32'h1;
        if (sclk === 1'b0) low_run <= low_run + 32'h1;
        else if (low_run != 32'h0) begin
            low_w <= low_run;
            low_run <= 32'h0;
        end
    end
    // Every test here ends well inside this ceiling
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    function automatic int cdiv(input int a, input int b);
        return (a + b - 1) / b;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
        v = rdata;
    endtask
    task automatic wait_status(input int b, input logic v);
        logic [31:0] s;
        s = {32{~v}};
        for (int i = 0; i < 600 && s[b] !== v; i++) reg_read(ADDR_STATUS, s);
        repeat (2) @(posedge mclk);
    endtask
    task automatic run_row(input asdp_row_t r);
        logic [31:0] v [6];
        int per, lw;
        v = '{32'(r.conf), 32'(r.pre), 32'(r.t1), r.t2, 32'(r.hsp), 32'(r.data)};
        per = cdiv(int'(r.t1[7:0]), int'(r.hsp));
        lw = (cdiv(2 * r.t2[7:0], r.hsp) + 1) / 2 - (cdiv(2 * r.t2[15:8], r.hsp) + 1) / 2;
        foreach (v[i]) reg_write(amap[i], v[i]);
        frame_len = 32'h0;
        reg_write(ADDR_CTRL, r.ctl);
        wait_status(ST_BUSY, 1'b0);
        chk(32'(nbits), 32'(r.nb));
        chk(cap, r.cap);
        chk(32'(rs_cap), 32'(r.rs));
        chk(frame_len, 32'(r.nb * per));
        chk(low_w, 32'(lw));
    endtask
    task automatic give_verdict();
        if (err_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        chk(32'({cs, sclk, oe}), 32'hF);
        resetn <= 1'b1;
        repeat (2) @(posedge mclk);
        foreach (rst_a[i]) begin
            reg_read(rst_a[i], d);
            chk(d, rst_v[i]);
        end
        foreach (rows[i]) run_row(rows[i]);
        reg_write(ADDR_TXDATA, 32'h12);
        reg_write(ADDR_CTRL, 32'h109);
        wait_status(ST_STALL, 1'b1);
        chk(32'({cs, sclk}), 32'h3);
        reg_write(ADDR_TXDATA, 32'h34);
        wait_status(ST_BUSY, 1'b0);
        chk(32'(nbits), 32'h12);
        chk(cap, 32'h1234);
        reply <= 16'hA53C;
        frame_len = 32'h0;
        reg_write(ADDR_CTRL, 32'h103);
        wait_status(ST_RXVALID, 1'b1);
        reg_read(ADDR_RXDATA, d);
        chk(d, 32'hA5);
        wait_status(ST_RXVALID, 1'b1);
        reg_read(ADDR_RXDATA, d);
        chk(d, 32'h3C);
        wait_status(ST_BUSY, 1'b0);
        chk(frame_len, 32'h90);
        chk(32'(nbits), 32'h2);
        chk(cap, 32'h1);
        reg_write(ADDR_CONF1, 32'h01E8);
        reg_write(ADDR_TXDATA, 32'h77);
        reg_write(ADDR_CTRL, 32'h9);
        wait_status(ST_BUSY, 1'b0);
        chk(32'(sclk), 32'h0);
        give_verdict();
    end
endmodule // asdp_port_tb
`default_nettype wire
